//--- rtl/tumux_pkg.sv
// Notes on behaviour
// - tributary pointer is the binary byte offset of container start from the anchor pointer byte, counted in tributary bytes.
// - pointer tracks phase and frame-rate differences between container and VC-4; here it tracks phase only, no justification.
// - a TUG-2 carries one TU-2 or up to three TU-12; VC-11 rides a TU-12.
// - a TUG-3 holds one TU-3 or up to seven TUG-2.
// - a VC-4 payload holds up to three TUG-3, each structured independently.
// - unallocated payload positions carry fixed stuff.
// - one tributary only is supported; more is optional.
// - C2 and H4 handled here; J1, B3, G1 left to path termination; rest unused.
// - transmit pointer derived from phase of low-order versus high-order container.
// - pointer plus container forms TU-3 (VC-3) or TU-12 (VC-1).
// - TU-12 into TUG-2 into TUG-3, TU-3 straight into TUG-3, TUG-3s into C-4.
// - transmitted C2 is 02h, TUG structure.
// - H4 undefined for TU-3 only, else multiframe indicator for TU-12 pointers.
// - assembled VC-4 goes to transport terminal; received VC-4 comes from it.
// - receive side extracts and monitors C2 and H4.
// - receive side demultiplexes TUG-3, TUG-2 and TU down to the tributary.
// - receive side interprets each tributary pointer to find container start.
// - receive side regenerates a gapped container clock from pointer and reference.
// - recovered container and its gapped clock go to low-order path termination.
// - VC-4 is 9 rows by 261 columns, path overhead in the first column.
package tumux_pkg;
  localparam logic [3:0] VC4_LAST_ROW = 4'h8;
  localparam logic [8:0] VC4_LAST_COL = 9'h104;  // 261 columns
  localparam logic [8:0] VC4_PAY_COL  = 9'h003;  // poh + two stuff columns
  localparam logic [3:0] C2_ROW       = 4'h2;
  localparam logic [3:0] H4_ROW       = 4'h5;
  localparam logic [7:0] C2_TUG       = 8'h02;
  localparam logic [7:0] H4_UNDEF     = 8'h00;
  localparam logic [5:0] H4_FILL      = 6'h3f;
  localparam logic [7:0] FIXED_STUFF  = 8'h00;
  localparam logic [7:0] NPI_BYTE1    = 8'h93;
  localparam logic [7:0] NPI_BYTE2    = 8'he0;
  localparam logic [3:0] NDF_NORM     = 4'h6;
  localparam logic [3:0] NDF_NEW      = 4'h9;
  localparam logic [1:0] SS_BITS      = 2'h2;
  localparam logic [9:0] TU3_SLOTS    = 10'h2fd; // 765 payload bytes per frame
  localparam logic [9:0] TU12_SLOTS   = 10'h08c; // 140 per 4-frame multiframe
  localparam logic [1:0] PTR_ACCEPT   = 2'h3;
  typedef enum logic [1:0] {
    PT_LOP  = 2'b00,
    PT_ACQ  = 2'b01,
    PT_LOCK = 2'b11
  } tumux_ptr_st_t;
endpackage

//--- rtl/tumux_slot_map.sv
`timescale 1ns/100ps
// walks the 9x261 VC-4 grid and classifies each byte position
module tumux_slot_map
  import tumux_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       srst,
  input  wire logic       step,
  input  wire logic       restart,
  input  wire logic       tu3_mode,
  output logic      [3:0] row,
  output logic      [3:0] tucol,
  output logic            last,
  output logic            is_poh,
  output logic            is_ptr,
  output logic            is_npi,
  output logic            is_trib
);
  logic [3:0] row_reg;
  logic [8:0] col_reg;
  logic [8:0] col;
  logic [8:0] p;
  logic [8:0] tcol;
  logic [1:0] tug;
  logic [6:0] q;
  logic [2:0] tug2;
  logic       base;
  logic       own12;

  // restart marks the current byte as row 0 column 0
  assign row  = restart ? 4'h0 : row_reg;
  assign col  = restart ? 9'h000 : col_reg;
  assign last = (row == VC4_LAST_ROW) && (col == VC4_LAST_COL);

  // row-major walk over the frame
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      row_reg <= 4'h0;
      col_reg <= 9'h000;
    end else if (step) begin
      if (col == VC4_LAST_COL) begin
        col_reg <= 9'h000;
        row_reg <= (row == VC4_LAST_ROW) ? 4'h0 : 4'(row + 4'h1);
      end else begin
        row_reg <= row;
        col_reg <= 9'(col + 9'h001);
      end
    end
  end

  // three tug-3 interleaved, then seven tug-2, then three tu-12
  always_comb begin
    p     = 9'(col - VC4_PAY_COL);
    tug   = 2'(p % 9'h003);
    tcol  = p / 9'h003;
    q     = 7'(tcol - 9'h002);
    tug2  = 3'(q % 7'h07);
    tucol = 4'(q / 7'h07);
    base  = (col >= VC4_PAY_COL) && (tug == 2'h0);
    own12 = base && (tcol >= 9'h002) && (tug2 == 3'h0) && (tucol % 4'h3 == 4'h0);
    is_poh = (col == 9'h000);
    is_npi = !tu3_mode && base && (tcol == 9'h000) && (row < 4'h2);
    if (tu3_mode) begin
      is_ptr  = base && (tcol == 9'h000) && (row < 4'h3);
      is_trib = base && (tcol != 9'h000);
    end else begin
      is_ptr  = own12 && (row == 4'h0) && (tucol == 4'h0);
      is_trib = own12 && !((row == 4'h0) && (tucol == 4'h0));
    end
  end
endmodule

//--- rtl/tumux_adapt.sv
`timescale 1ns/100ps
// single-tributary vc-4 adaptation: tu-3 or tu-12 in tug-3 number one
module tumux_adapt
  import tumux_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       srst,
  input  wire logic       cfg_tu3,
  input  wire logic       tx_vc4_req,
  output logic      [7:0] tx_vc4_data,
  output logic            tx_vc4_valid,
  output logic            tx_vc4_fs,
  output logic            lo_tx_req,
  input  wire logic [7:0] lo_tx_data,
  input  wire logic       lo_tx_start,
  input  wire logic [7:0] rx_vc4_data,
  input  wire logic       rx_vc4_valid,
  input  wire logic       rx_vc4_fs,
  output logic      [7:0] lo_rx_data,
  output logic            lo_rx_gclk,
  output logic            lo_rx_start,
  output logic      [7:0] rx_c2,
  output logic            rx_c2_mismatch,
  output logic            rx_h4_mismatch,
  output logic      [9:0] rx_ptr,
  output logic            rx_ptr_lock
);
  logic [3:0]    tx_row, rx_row;
  logic          tx_last, tx_poh, tx_ptr, tx_npi, tx_trib;
  logic          rx_poh, rx_ptrpos, rx_trib;
  logic [1:0]    tx_mf_reg;
  logic [9:0]    tx_ofs_reg;
  logic [9:0]    tx_ofs1_reg;
  logic [9:0]    tx_ptr_reg;
  logic          tx_ndf_reg;
  logic [9:0]    tx_snap_reg;
  logic          tx_snap_ndf_reg;
  logic [7:0]    tx_fix_reg;
  logic          tx_take_reg;
  logic          tx_s1_valid_reg;
  logic          tx_s1_fs_reg;
  logic [7:0]    tx_vc4_data_reg;
  logic          tx_vc4_valid_reg;
  logic          tx_vc4_fs_reg;
  logic          lo_tx_req_reg;
  logic [7:0]    tx_fix_next;
  logic [9:0]    slots;
  logic          tx_anchor, tx_b1, tx_b2;
  logic [1:0]    rx_mf_reg;
  logic [1:0]    rx_h4_last_reg;
  logic [9:0]    rx_ofs_reg;
  logic [7:0]    rx_b1_reg;
  logic [9:0]    rx_cand_reg;
  logic [1:0]    rx_cnt_reg;
  tumux_ptr_st_t rx_st_reg;
  logic [9:0]    rx_ptr_reg;
  logic [7:0]    lo_rx_data_reg;
  logic          lo_rx_gclk_reg;
  logic          lo_rx_start_reg;
  logic [7:0]    rx_c2_reg;
  logic          rx_c2_mismatch_reg;
  logic          rx_h4_mismatch_reg;
  logic          rx_anchor, rx_b1, rx_b2;
  logic [9:0]    rx_cand_w;
  logic          rx_inrange;

  tumux_slot_map u_tx_map (
    .ref_clk  (ref_clk),
    .srst     (srst),
    .step     (tx_vc4_req),
    .restart  (1'b0),
    .tu3_mode (cfg_tu3),
    .row      (tx_row),
    .tucol    (),
    .last     (tx_last),
    .is_poh   (tx_poh),
    .is_ptr   (tx_ptr),
    .is_npi   (tx_npi),
    .is_trib  (tx_trib)
  );

  tumux_slot_map u_rx_map (
    .ref_clk  (ref_clk),
    .srst     (srst),
    .step     (rx_vc4_valid),
    .restart  (rx_vc4_fs),
    .tu3_mode (cfg_tu3),
    .row      (rx_row),
    .tucol    (),
    .last     (),
    .is_poh   (rx_poh),
    .is_ptr   (rx_ptrpos),
    .is_npi   (),
    .is_trib  (rx_trib)
  );

  // pointer byte roles; the anchor byte restarts the offset count
  assign slots     = cfg_tu3 ? TU3_SLOTS : TU12_SLOTS;
  assign tx_b1     = tx_ptr && (cfg_tu3 ? (tx_row == 4'h0) : (tx_mf_reg == 2'h0));
  assign tx_b2     = tx_ptr && (cfg_tu3 ? (tx_row == 4'h1) : (tx_mf_reg == 2'h1));
  assign tx_anchor = tx_ptr && (cfg_tu3 ? (tx_row == 4'h2) : (tx_mf_reg == 2'h1));
  assign rx_b1     = rx_ptrpos && (cfg_tu3 ? (rx_row == 4'h0) : (rx_mf_reg == 2'h0));
  assign rx_b2     = rx_ptrpos && (cfg_tu3 ? (rx_row == 4'h1) : (rx_mf_reg == 2'h1));
  assign rx_anchor = rx_ptrpos && (cfg_tu3 ? (rx_row == 4'h2) : (rx_mf_reg == 2'h1));
  assign rx_cand_w  = {rx_b1_reg[1:0], rx_vc4_data};
  assign rx_inrange = rx_cand_w < slots;

  // byte for every non-tributary position of the outgoing frame
  always_comb begin
    tx_fix_next = FIXED_STUFF;
    if (tx_poh) begin
      if (tx_row == C2_ROW) begin
        tx_fix_next = C2_TUG;
      end else if (tx_row == H4_ROW) begin
        tx_fix_next = cfg_tu3 ? H4_UNDEF : {H4_FILL, 2'(tx_mf_reg + 2'h1)};
      end
    end else if (tx_b1) begin
      tx_fix_next = {tx_ndf_reg ? NDF_NEW : NDF_NORM, SS_BITS, tx_ptr_reg[9:8]};
    end else if (tx_b2) begin
      tx_fix_next = tx_snap_reg[7:0];
    end else if (tx_npi) begin
      tx_fix_next = (tx_row == 4'h0) ? NPI_BYTE1 : NPI_BYTE2;
    end
  end

  // stage one: classify the slot, ask the tributary for a byte
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      tx_fix_reg      <= FIXED_STUFF;
      tx_take_reg     <= 1'b0;
      tx_s1_valid_reg <= 1'b0;
      tx_s1_fs_reg    <= 1'b0;
      lo_tx_req_reg   <= 1'b0;
    end else begin
      tx_fix_reg      <= tx_fix_next;
      tx_take_reg     <= tx_vc4_req && tx_trib;
      tx_s1_valid_reg <= tx_vc4_req;
      tx_s1_fs_reg    <= tx_vc4_req && tx_poh && (tx_row == 4'h0);
      lo_tx_req_reg   <= tx_vc4_req && tx_trib;
    end
  end

  // stage two: merge tributary byte into the vc-4 stream
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      tx_vc4_data_reg  <= 8'h00;
      tx_vc4_valid_reg <= 1'b0;
      tx_vc4_fs_reg    <= 1'b0;
    end else begin
      tx_vc4_data_reg  <= tx_take_reg ? lo_tx_data : tx_fix_reg;
      tx_vc4_valid_reg <= tx_s1_valid_reg;
      tx_vc4_fs_reg    <= tx_s1_fs_reg;
    end
  end

  // multiframe phase advances once per outgoing frame
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      tx_mf_reg <= 2'h0;
    end else if (tx_vc4_req && tx_last) begin
      tx_mf_reg <= 2'(tx_mf_reg + 2'h1);
    end
  end

  // payload offset since the anchor pointer byte
  // the source is paced by our requests, so no justification is ever needed
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      tx_ofs_reg  <= 10'h000;
      tx_ofs1_reg <= 10'h000;
    end else if (tx_vc4_req) begin
      if (tx_anchor) begin
        tx_ofs_reg <= 10'h000;
      end else if (tx_trib) begin
        tx_ofs1_reg <= tx_ofs_reg;
        tx_ofs_reg  <= (tx_ofs_reg == 10'(slots - 10'h001)) ? 10'h000 : 10'(tx_ofs_reg + 10'h001);
      end
    end
  end

  // pointer follows the offset at which the container starts
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      tx_ptr_reg <= 10'h000;
      tx_ndf_reg <= 1'b0;
    end else if (tx_take_reg && lo_tx_start && (tx_ofs1_reg != tx_ptr_reg)) begin
      tx_ptr_reg <= tx_ofs1_reg;
      tx_ndf_reg <= 1'b1;
    end else if (tx_vc4_req && tx_b2 && tx_snap_ndf_reg) begin
      tx_ndf_reg <= 1'b0; // new data flag sent once, set wins above
    end
  end

  // low byte sent later must match the high bits already sent
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      tx_snap_reg     <= 10'h000;
      tx_snap_ndf_reg <= 1'b0;
    end else if (tx_vc4_req && tx_b1) begin
      tx_snap_reg     <= tx_ptr_reg;
      tx_snap_ndf_reg <= tx_ndf_reg;
    end
  end

  // overhead monitoring of the received vc-4
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rx_c2_reg          <= 8'h00;
      rx_c2_mismatch_reg <= 1'b0;
      rx_h4_mismatch_reg <= 1'b0;
      rx_h4_last_reg     <= 2'h0;
      rx_mf_reg          <= 2'h0;
    end else if (rx_vc4_valid) begin
      if (rx_vc4_fs) begin
        rx_mf_reg <= rx_h4_last_reg; // h4 announces the next frame
      end
      if (rx_poh && (rx_row == C2_ROW)) begin
        rx_c2_reg          <= rx_vc4_data;
        rx_c2_mismatch_reg <= rx_vc4_data != C2_TUG;
      end
      if (rx_poh && (rx_row == H4_ROW)) begin
        rx_h4_last_reg     <= rx_vc4_data[1:0];
        rx_h4_mismatch_reg <= !cfg_tu3 && (rx_vc4_data[1:0] != 2'(rx_h4_last_reg + 2'h1));
      end
    end
  end

  // pointer interpretation: new data flag is taken at once,
  // a plain change needs PTR_ACCEPT equal values in a row
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rx_b1_reg   <= 8'h00;
      rx_cand_reg <= 10'h000;
      rx_cnt_reg  <= 2'h0;
      rx_st_reg   <= PT_LOP;
      rx_ptr_reg  <= 10'h000;
    end else if (rx_vc4_valid && rx_b1) begin
      rx_b1_reg <= rx_vc4_data;
    end else if (rx_vc4_valid && rx_b2 && rx_inrange) begin
      if (rx_b1_reg[7:4] == NDF_NEW) begin
        rx_ptr_reg <= rx_cand_w;
        rx_st_reg  <= PT_LOCK;
        rx_cnt_reg <= 2'h0;
      end else if (rx_b1_reg[7:4] == NDF_NORM) begin
        case (rx_st_reg)
          PT_LOCK: begin
            if (rx_cand_w != rx_ptr_reg) begin
              rx_cand_reg <= rx_cand_w;
              rx_cnt_reg  <= 2'h1;
              rx_st_reg   <= PT_ACQ;
            end
          end
          default: begin
            if ((rx_cand_w == rx_cand_reg) && (rx_cnt_reg != 2'h0)) begin
              rx_cnt_reg <= 2'(rx_cnt_reg + 2'h1);
              if (2'(rx_cnt_reg + 2'h1) == PTR_ACCEPT) begin
                rx_ptr_reg <= rx_cand_w;
                rx_st_reg  <= PT_LOCK;
              end
            end else begin
              rx_cand_reg <= rx_cand_w;
              rx_cnt_reg  <= 2'h1;
              rx_st_reg   <= (rx_st_reg == PT_LOP) ? PT_ACQ : rx_st_reg;
            end
          end
        endcase
      end
    end
  end

  // receive payload offset, same anchoring as transmit
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rx_ofs_reg <= 10'h000;
    end else if (rx_vc4_valid) begin
      if (rx_anchor) begin
        rx_ofs_reg <= 10'h000;
      end else if (rx_trib) begin
        rx_ofs_reg <= (rx_ofs_reg == 10'(slots - 10'h001)) ? 10'h000 : 10'(rx_ofs_reg + 10'h001);
      end
    end
  end

  // demultiplexed bytes with gapped clock, held off until a pointer is seen
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      lo_rx_data_reg  <= 8'h00;
      lo_rx_gclk_reg  <= 1'b0;
      lo_rx_start_reg <= 1'b0;
    end else begin
      lo_rx_gclk_reg  <= rx_vc4_valid && rx_trib && (rx_st_reg != PT_LOP);
      lo_rx_start_reg <= rx_vc4_valid && rx_trib && (rx_st_reg != PT_LOP)
                         && (rx_ofs_reg == rx_ptr_reg);
      if (rx_vc4_valid && rx_trib) begin
        lo_rx_data_reg <= rx_vc4_data;
      end
    end
  end

  assign tx_vc4_data    = tx_vc4_data_reg;
  assign tx_vc4_valid   = tx_vc4_valid_reg;
  assign tx_vc4_fs      = tx_vc4_fs_reg;
  assign lo_tx_req      = lo_tx_req_reg;
  assign lo_rx_data     = lo_rx_data_reg;
  assign lo_rx_gclk     = lo_rx_gclk_reg;
  assign lo_rx_start    = lo_rx_start_reg;
  assign rx_c2          = rx_c2_reg;
  assign rx_c2_mismatch = rx_c2_mismatch_reg;
  assign rx_h4_mismatch = rx_h4_mismatch_reg;
  assign rx_ptr         = rx_ptr_reg;
  assign rx_ptr_lock    = rx_st_reg[1]; // only the lock code has its upper bit set

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  sequence s_c2_slot;
    tx_vc4_req && tx_poh && (tx_row == C2_ROW);
  endsequence
  sequence s_new_ptr;
    rx_vc4_valid && rx_b2 && rx_inrange && (rx_b1_reg[7:4] == NDF_NEW);
  endsequence

  property p_c2_value;
    s_c2_slot |-> ##2 tx_vc4_valid_reg && (tx_vc4_data_reg == C2_TUG);
  endproperty
  a_c2_value: assert property (p_c2_value) else $error("c2 not 02h");
  property p_req_latency;
    tx_vc4_req |-> ##1 !tx_vc4_valid_reg || $past(tx_vc4_req, 2) ##1 tx_vc4_valid_reg;
  endproperty
  a_req_latency: assert property (p_req_latency) else $error("vc-4 byte late");
  property p_lo_req;
    tx_vc4_req && tx_trib |=> lo_tx_req_reg ##1 tx_vc4_data_reg == $past(lo_tx_data);
  endproperty
  a_lo_req: assert property (p_lo_req) else $error("tributary byte lost");
  property p_stuff;
    tx_vc4_req && !tx_poh && !tx_ptr && !tx_npi && !tx_trib |-> ##2 tx_vc4_data_reg == FIXED_STUFF;
  endproperty
  a_stuff: assert property (p_stuff) else $error("unused slot not stuffed");
  property p_h4_mf;
    !cfg_tu3 && tx_vc4_req && tx_poh && (tx_row == H4_ROW)
      |-> ##2 tx_vc4_data_reg == {H4_FILL, 2'($past(tx_mf_reg, 2) + 2'h1)};
  endproperty
  a_h4_mf: assert property (p_h4_mf) else $error("h4 multiframe wrong");
  property p_ptr_follow;
    tx_take_reg && lo_tx_start && (tx_ofs1_reg != tx_ptr_reg)
      |=> tx_ndf_reg && (tx_ptr_reg == $past(tx_ofs1_reg));
  endproperty
  a_ptr_follow: assert property (p_ptr_follow) else $error("pointer not updated");
  property p_c2_mon;
    rx_vc4_valid && rx_poh && (rx_row == C2_ROW)
      |=> rx_c2_mismatch_reg == ($past(rx_vc4_data) != C2_TUG);
  endproperty
  a_c2_mon: assert property (p_c2_mon) else $error("c2 monitor wrong");
  property p_gclk;
    rx_vc4_valid && rx_trib && (rx_st_reg != PT_LOP)
      |=> lo_rx_gclk_reg && (lo_rx_data_reg == $past(rx_vc4_data));
  endproperty
  a_gclk: assert property (p_gclk) else $error("gapped clock missing");
  property p_new_ptr;
    s_new_ptr |=> (rx_ptr_reg == $past(rx_cand_w)) && (rx_st_reg == PT_LOCK);
  endproperty
  a_new_ptr: assert property (p_new_ptr) else $error("new pointer not taken");
  property p_no_gap;
    !rx_vc4_valid |=> !lo_rx_gclk_reg && !lo_rx_start_reg;
  endproperty
  a_no_gap: assert property (p_no_gap) else $error("clock without byte");
endmodule

//--- verif/tumux_trib_src.sv
`timescale 1ns/100ps
// low-order container source answering the adaptation's byte requests
module tumux_trib_src (
  input  wire logic       ref_clk,
  input  wire logic       srst,
  input  wire logic [9:0] frame_len,
  input  wire logic       lo_tx_req,
  output logic      [7:0] lo_tx_data,
  output logic            lo_tx_start
);
  logic [9:0] idx_reg;
  logic [7:0] junk_reg;

  // the byte stands while the request does: the adaptation takes it at the
  // edge that ends the request cycle, so a registered answer would be late
  assign lo_tx_data  = lo_tx_req ? idx_reg[7:0] : junk_reg;
  assign lo_tx_start = lo_tx_req ? (idx_reg == 10'h000) : junk_reg[0];

  // byte value is its offset in the container so the far end can check order
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      idx_reg  <= 10'h000;
      junk_reg <= 8'h5a;
    end else begin
      // outside the answer cycle the lines carry garbage, never the last byte
      junk_reg <= ~junk_reg;
      if (lo_tx_req) begin
        idx_reg <= (idx_reg == frame_len - 10'h001) ? 10'h000 : idx_reg + 10'h001;
      end
    end
  end
endmodule

//--- verif/tb.sv
`timescale 1ns/100ps
// loopback bench: tx vc-4 stream fed back into the receive side
module tb;
  import tumux_pkg::*;
  logic        ref_clk, srst, cfg_tu3, tx_vc4_req, tx_vc4_valid, tx_vc4_fs;
  logic        lo_tx_req, lo_tx_start, rx_vc4_valid, rx_vc4_fs, lo_rx_gclk, lo_rx_start;
  logic        rx_c2_mismatch, rx_h4_mismatch, rx_ptr_lock;
  logic        req_d1, req_d2, req_en, check_en, corrupt, synced;
  logic [7:0]  tx_vc4_data, lo_tx_data, rx_vc4_data, lo_rx_data, rx_c2;
  logic [9:0]  rx_ptr, frame_len, rx_idx;
  logic [15:0] lfsr;
  logic [3:0]  row;
  logic [8:0]  col, fx;
  logic [1:0]  h4_exp;
  int          fails, n_tests, cyc;

  tumux_adapt dut (
    .ref_clk(ref_clk), .srst(srst), .cfg_tu3(cfg_tu3), .tx_vc4_req(tx_vc4_req),
    .tx_vc4_data(tx_vc4_data), .tx_vc4_valid(tx_vc4_valid), .tx_vc4_fs(tx_vc4_fs),
    .lo_tx_req(lo_tx_req), .lo_tx_data(lo_tx_data), .lo_tx_start(lo_tx_start),
    .rx_vc4_data(rx_vc4_data), .rx_vc4_valid(rx_vc4_valid), .rx_vc4_fs(rx_vc4_fs),
    .lo_rx_data(lo_rx_data), .lo_rx_gclk(lo_rx_gclk), .lo_rx_start(lo_rx_start),
    .rx_c2(rx_c2), .rx_c2_mismatch(rx_c2_mismatch), .rx_h4_mismatch(rx_h4_mismatch),
    .rx_ptr(rx_ptr), .rx_ptr_lock(rx_ptr_lock)
  );

  tumux_trib_src trib_src (
    .ref_clk(ref_clk), .srst(srst), .frame_len(frame_len),
    .lo_tx_req(lo_tx_req), .lo_tx_data(lo_tx_data), .lo_tx_start(lo_tx_start)
  );

  function automatic logic [15:0] lfsr_next(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  // bit 8 set when the byte is fixed by structure alone
  function automatic logic [8:0] fixed_byte(input logic [3:0] r, input logic [8:0] c,
                                            input logic tu3);
    if (c == 9'h000) begin
      if (r == 4'h2) return 9'h102;
      if (r == 4'h5 && !tu3) return 9'h000;
      return 9'h100;
    end
    // only tug-3 number one carries a tributary, the others are stuff
    if (c < 9'h003 || (c - 9'h003) % 3 != 0) return 9'h100;
    return 9'h000;
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // random request gaps, loopback and tx frame layout checks
  always @(posedge ref_clk) begin
    lfsr         <= lfsr_next(lfsr);
    tx_vc4_req   <= req_en && (lfsr[2:0] != 3'h0);
    rx_vc4_valid <= tx_vc4_valid;
    rx_vc4_fs    <= tx_vc4_fs;
    rx_vc4_data  <= tx_vc4_valid ?
                    tx_vc4_data ^ ((corrupt && row == 4'h2 && col == 9'h000) ? 8'hff : 8'h00) :
                    lfsr[15:8];
    if (srst) begin
      row    <= 4'h0;
      col    <= 9'h000;
      h4_exp <= 2'h1;
      req_d1 <= 1'b0;
      req_d2 <= 1'b0;
    end else begin
      req_d1 <= tx_vc4_req;
      req_d2 <= req_d1;
      chk(16'(tx_vc4_valid), 16'(req_d2));
      if (tx_vc4_valid) begin
        chk(16'(tx_vc4_fs), 16'(row == 4'h0 && col == 9'h000));
        fx = fixed_byte(row, col, cfg_tu3);
        if (fx[8]) chk(16'(tx_vc4_data), 16'(fx[7:0]));
        else if (col == 9'h000) begin
          chk(16'(tx_vc4_data), {8'h00, 6'h3f, h4_exp});
          h4_exp <= h4_exp + 2'h1;
        end
        if (col == 9'h104) begin
          col <= 9'h000;
          row <= (row == 4'h8) ? 4'h0 : row + 4'h1;
        end else col <= col + 9'h001;
      end
    end
  end

  // recovered container must come out in order, starting on the pointer
  always @(posedge ref_clk) begin
    if (srst || !check_en) begin
      synced <= 1'b0;
      rx_idx <= 10'h000;
    end else if (lo_rx_gclk) begin
      if (synced) chk(16'(lo_rx_start), 16'(rx_idx == frame_len));
      if (synced || lo_rx_start)
        chk(16'(lo_rx_data), (lo_rx_start && !synced) || rx_idx == frame_len ?
            16'h0000 : 16'(rx_idx[7:0]));
      if (synced ? rx_idx == frame_len : lo_rx_start) rx_idx <= 10'h001;
      else rx_idx <= rx_idx + 10'h001;
      if (lo_rx_start) synced <= 1'b1;
    end
  end

  // hang guard, about half again the expected run length
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 90000) begin
      fails++;
      stop_test();
    end
  end

  task automatic wait_frames(input int n);
    repeat (n) @(posedge ref_clk iff tx_vc4_fs);
    #1;
  endtask

  task automatic run_mode(input logic tu3);
    @(posedge ref_clk);
    srst      <= 1'b1;
    req_en    <= 1'b0;
    check_en  <= 1'b0;
    cfg_tu3   <= tu3;
    frame_len <= tu3 ? 10'h2fd : 10'h08c;
    repeat (10) @(posedge ref_clk);
    srst   <= 1'b0;
    req_en <= 1'b1;
    wait_frames(tu3 ? 4 : 8);
    check_en <= 1'b1;
    // tu-12 locks in the tenth frame, the next container start is in the thirteenth
    wait_frames(tu3 ? 2 : 6);
    chk(16'(rx_c2), 16'h0002);
    chk(16'(rx_c2_mismatch), 16'h0000);
    chk(16'(rx_h4_mismatch), 16'h0000);
    chk(16'(rx_ptr_lock), 16'h0001);
    // start lands after the bytes sent ahead of the first anchor: 765-170, 140-35
    chk(16'(rx_ptr), tu3 ? 16'h0253 : 16'h0069);
    chk(16'(synced), 16'h0001);
    if (tu3) begin
      // a damaged signal label must be flagged, then clear again
      corrupt <= 1'b1;
      wait_frames(2);
      chk(16'(rx_c2), 16'h00fd);
      chk(16'(rx_c2_mismatch), 16'h0001);
      corrupt <= 1'b0;
      wait_frames(2);
      chk(16'(rx_c2), 16'h0002);
      chk(16'(rx_c2_mismatch), 16'h0000);
    end
  endtask

  initial begin
    srst        = 1'b1;
    cfg_tu3     = 1'b1;
    tx_vc4_req  = 1'b0;
    rx_vc4_data = 8'h00;
    rx_vc4_valid = 1'b0;
    rx_vc4_fs   = 1'b0;
    req_en      = 1'b0;
    check_en    = 1'b0;
    corrupt     = 1'b0;
    frame_len   = 10'h2fd;
    lfsr        = 16'hec14;
    fails       = 0;
    n_tests     = 0;
    cyc         = 0;
    run_mode(1'b1);
    // second run starts with a mid-run reset and the other structure
    run_mode(1'b0);
    stop_test();
  end
endmodule
